//--- rtl/rjm_pkg.sv
// Shared constants and types for the reverse justified string move block
package rjm_pkg;
	// Register word offsets (byte addresses on the bus)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_R0 = 8'h08;
	localparam logic [7:0] OFF_R1 = 8'h0c;
	localparam logic [7:0] OFF_R2 = 8'h10;
	localparam logic [7:0] OFF_R3 = 8'h14;
	localparam logic [7:0] OFF_R4 = 8'h18;
	localparam logic [7:0] OFF_PC = 8'h1c;
	localparam int NUM_REGS = 8;

	// Register indices derived from the offsets
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_R0 = 3'h2;
	localparam logic [2:0] IDX_R4 = 3'h6;
	localparam logic [2:0] IDX_PC = 3'h7;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_INLINE = 1;
	localparam int CTRL_PAUSE = 2;

	// Status register fields
	localparam int ST_C = 0;
	localparam int ST_V = 1;
	localparam int ST_Z = 2;
	localparam int ST_N = 3;
	localparam int ST_BUSY = 8;
	localparam int ST_DONE = 9;
	localparam int ST_SUSP = 10;

	// Reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

	// Engine sequence
	typedef enum logic [3:0] {
		RJM_IDLE, RJM_PTR, RJM_LEN, RJM_ADR, RJM_FILL,
		RJM_FLAGS, RJM_STEP, RJM_RD, RJM_WR, RJM_END
	} rjm_state_t;
endpackage : rjm_pkg

//--- rtl/rjm_regs_if.sv
// Carrier between the bus slave and the move engine
`timescale 1ns/1ns
interface rjm_regs_if;
	logic wr_en;
	logic [2:0] wr_idx;
	logic [15:0] wr_data;
	logic [7:0][15:0] rd_word;

	modport slave (output wr_en, output wr_idx, output wr_data,
		input rd_word);
	modport engine (input wr_en, input wr_idx, input wr_data,
		output rd_word);
endinterface : rjm_regs_if

//--- rtl/rjm_apb.sv
// APB slave front end: decode, registered read data, error on holes
`timescale 1ns/1ns
module rjm_apb #(
	parameter int ADDR_W = 8
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	rjm_regs_if.slave regs
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pslverr;
	} rjm_apb_t;

	rjm_apb_t s;
	rjm_apb_t next_s;

	// Address is too narrow to reach the whole map
	if (ADDR_W < 5) begin : g_bad_width
		$error("rjm_apb: ADDR_W must be at least 5");
	end

	// Word aligned hit inside the map; upper bits must be zero
	function automatic logic hit(input logic [ADDR_W-1:0] a);
		hit = (a[1:0] == 2'b00) && ((a >> 5) == '0);
	endfunction : hit

	function automatic logic [2:0] index(input logic [ADDR_W-1:0] a);
		index = a[4:2];
	endfunction : index

	// No wait states: every access finishes in its first access cycle
	assign pready_o = 1'b1;
	assign prdata_o = s.prdata;
	assign pslverr_o = s.pslverr;

	// Writes land at the access edge, so the engine sees them once
	assign regs.wr_en = psel_i && penable_i && pwrite_i && hit(paddr_i);
	assign regs.wr_idx = index(paddr_i);
	assign regs.wr_data = pwdata_i[15:0];

	// Read data and error are captured in the setup cycle
	always_comb begin
		next_s = s;
		if (psel_i && !penable_i) begin
			next_s.pslverr = !hit(paddr_i);
			next_s.prdata = rjm_pkg::RST_PRDATA;
			if (hit(paddr_i) && !pwrite_i) begin
				next_s.prdata = {16'h0000,
					regs.rd_word[index(paddr_i)]};
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : rjm_apb

//--- rtl/rjm_top.sv
// Reverse justified string move engine with its register file
//
// How it works
// - N and Z from source minus destination length
// - V on signed overflow of length difference
// - C set on borrow, cleared on carry
// - Move may pause between characters and resume
// - Strings aligned on their last characters
// - Short source: pad leading destination, C set
// - Long source: drop leading source, Z C clear
// - Equal lengths copy all, Z set
// - Register form leaves count, zeros, fill
// - In-line form fetches two descriptor pointers
// - Third word is fill; PC steps by two
// - In-line form leaves R0-R4 untouched
// - Overlap never corrupts the result
// - Direction chosen by comparing end addresses
// - Upward: skip excess, pad, then copy
// - Downward: copy from ends, then pad
// - Vacant strings still update flags, registers
// - Final R0 zero only if Z or C
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module rjm_top #(
	parameter int ADDR_W = 8
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic mem_req_o,
	output logic mem_write_o,
	output logic mem_byte_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i
);
	typedef struct packed {
		rjm_pkg::rjm_state_t st;
		logic mreq;
		logic mwe;
		logic mbyte;
		logic [15:0] maddr;
		logic [15:0] mwdata;
		logic inl;
		logic pause;
		logic done;
		logic n;
		logic z;
		logic v;
		logic c;
		logic up;
		logic cpy;
		logic opn;
		logic [15:0] temp;
		logic [15:0] slen;
		logic [15:0] sadr;
		logic [15:0] dlen;
		logic [15:0] dadr;
		logic [7:0] fill;
		logic [4:0][15:0] gpr;
		logic [15:0] pc;
	} rjm_top_t;

	rjm_top_t s;
	rjm_top_t next_s;
	rjm_regs_if regs ();

	// The register map needs five byte address bits
	if (ADDR_W < 5) begin : g_bad_width
		$error("rjm_top: ADDR_W must be at least 5");
	end

	logic idle;
	logic take;
	logic start;
	logic [16:0] diff;
	logic [15:0] src_end;
	logic [15:0] dst_end;
	logic [15:0] status;

	rjm_apb #(
		.ADDR_W(ADDR_W)
	) u_apb (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.regs(regs.slave)
	);

	// Memory port straight from flip-flops
	assign mem_req_o = s.mreq;
	assign mem_write_o = s.mwe;
	assign mem_byte_o = s.mbyte;
	assign mem_addr_o = s.maddr;
	assign mem_wdata_o = s.mwdata;

	// Acknowledges with no request pending are ignored
	assign take = s.mreq && mem_ack_i;

	assign idle = (s.st == rjm_pkg::RJM_IDLE);
	// A start while busy is dropped, not queued
	assign start = regs.wr_en && idle
		&& (regs.wr_idx == rjm_pkg::IDX_CTRL)
		&& regs.wr_data[rjm_pkg::CTRL_START];

	// Borrow lands in bit 16 of a zero extended subtraction
	assign diff = {1'b0, s.slen} - {1'b0, s.dlen};
	assign src_end = 16'(s.slen + s.sadr - 16'h0001);
	assign dst_end = 16'(s.dlen + s.dadr - 16'h0001);

	// Pointer step in the chosen direction, shared by both strings
	function automatic logic [15:0] step_adr(input logic [15:0] a,
		input logic up);
		step_adr = up ? 16'(a + 16'h0001) : 16'(a - 16'h0001);
	endfunction : step_adr

	// Status word seen by software
	always_comb begin
		status = rjm_pkg::RST_WORD;
		status[rjm_pkg::ST_C] = s.c;
		status[rjm_pkg::ST_V] = s.v;
		status[rjm_pkg::ST_Z] = s.z;
		status[rjm_pkg::ST_N] = s.n;
		status[rjm_pkg::ST_BUSY] = !idle;
		status[rjm_pkg::ST_DONE] = s.done;
		status[rjm_pkg::ST_SUSP] = s.pause
			&& (s.st == rjm_pkg::RJM_STEP);
	end

	// Read view: control, status, then the general registers
	assign regs.rd_word[rjm_pkg::IDX_CTRL] = {13'h0000, s.pause, s.inl,
		1'b0};
	assign regs.rd_word[rjm_pkg::IDX_STATUS] = status;
	assign regs.rd_word[rjm_pkg::IDX_PC] = s.pc;
	for (genvar g = 0; g < 5; g++) begin : g_gpr_view
		assign regs.rd_word[g + 2] = s.gpr[g];
	end

	// Engine sequence and register writes
	always_comb begin
		next_s = s;

		// A request drops at its acknowledge; new ones may follow
		if (take) begin
			next_s.mreq = 1'b0;
		end

		// Software writes; the operands are frozen while busy
		if (regs.wr_en) begin
			if (regs.wr_idx == rjm_pkg::IDX_CTRL) begin
				next_s.pause = regs.wr_data[rjm_pkg::CTRL_PAUSE];
				if (idle) begin
					next_s.inl = regs.wr_data[rjm_pkg::CTRL_INLINE];
				end
			end else if (idle && regs.wr_idx == rjm_pkg::IDX_PC) begin
				next_s.pc = regs.wr_data;
			end else if (idle && regs.wr_idx >= rjm_pkg::IDX_R0
					&& regs.wr_idx <= rjm_pkg::IDX_R4) begin
				next_s.gpr[3'(regs.wr_idx - rjm_pkg::IDX_R0)] =
					regs.wr_data;
			end
		end

		case (s.st)
			rjm_pkg::RJM_IDLE: begin
				if (start) begin
					next_s.done = 1'b0;
					next_s.opn = 1'b0;
					if (regs.wr_data[rjm_pkg::CTRL_INLINE]) begin
						// First pointer sits at the program counter
						next_s.mreq = 1'b1;
						next_s.mwe = 1'b0;
						next_s.mbyte = 1'b0;
						next_s.maddr = s.pc;
						next_s.st = rjm_pkg::RJM_PTR;
					end else begin
						// Descriptors and fill come from the registers
						next_s.slen = s.gpr[0];
						next_s.sadr = s.gpr[1];
						next_s.dlen = s.gpr[2];
						next_s.dadr = s.gpr[3];
						next_s.fill = s.gpr[4][7:0];
						next_s.st = rjm_pkg::RJM_FLAGS;
					end
				end
			end
			rjm_pkg::RJM_PTR: begin
				if (take) begin
					next_s.temp = mem_rdata_i;
					next_s.pc = 16'(s.pc + 16'h0002);
					next_s.mreq = 1'b1;
					next_s.maddr = mem_rdata_i;
					next_s.st = rjm_pkg::RJM_LEN;
				end
			end
			rjm_pkg::RJM_LEN: begin
				if (take) begin
					if (s.opn) begin
						next_s.dlen = mem_rdata_i;
					end else begin
						next_s.slen = mem_rdata_i;
					end
					next_s.mreq = 1'b1;
					next_s.maddr = 16'(s.temp + 16'h0002);
					next_s.st = rjm_pkg::RJM_ADR;
				end
			end
			rjm_pkg::RJM_ADR: begin
				if (take) begin
					next_s.mreq = 1'b1;
					next_s.maddr = s.pc;
					if (s.opn) begin
						next_s.dadr = mem_rdata_i;
						next_s.st = rjm_pkg::RJM_FILL;
					end else begin
						// Source done, destination pointer next
						next_s.sadr = mem_rdata_i;
						next_s.opn = 1'b1;
						next_s.st = rjm_pkg::RJM_PTR;
					end
				end
			end
			rjm_pkg::RJM_FILL: begin
				if (take) begin
					// High half of the fill word is ignored
					next_s.fill = mem_rdata_i[7:0];
					next_s.pc = 16'(s.pc + 16'h0002);
					next_s.st = rjm_pkg::RJM_FLAGS;
				end
			end
			rjm_pkg::RJM_FLAGS: begin
				// Flags reflect the initial lengths only
				next_s.n = diff[15];
				next_s.z = (diff[15:0] == 16'h0000);
				next_s.v = (s.slen[15] != s.dlen[15])
					&& (s.dlen[15] == diff[15]);
				next_s.c = diff[16];
				// Copy away from the overlap: no write may land on a
				// source byte that has still to be read
				next_s.up = (src_end >= dst_end);
				if (src_end >= dst_end) begin
					// Skip the leading source characters that overflow
					if (s.slen > s.dlen) begin
						next_s.sadr = 16'(s.sadr + s.slen - s.dlen);
					end
				end else begin
					next_s.sadr = src_end;
					next_s.dadr = dst_end;
				end
				next_s.st = rjm_pkg::RJM_STEP;
			end
			rjm_pkg::RJM_STEP: begin
				// Only stop point: pointers and counts are consistent
				// Resume starts again at the same character
				if (s.pause) begin
					next_s.st = rjm_pkg::RJM_STEP;
				end else if (s.dlen == 16'h0000) begin
					next_s.st = rjm_pkg::RJM_END;
				end else if (s.up ? (s.slen >= s.dlen)
						: (s.slen != 16'h0000)) begin
					// Direction keeps each read ahead of the writes
					next_s.cpy = 1'b1;
					next_s.mreq = 1'b1;
					next_s.mwe = 1'b0;
					next_s.mbyte = 1'b1;
					next_s.maddr = s.sadr;
					next_s.st = rjm_pkg::RJM_RD;
				end else begin
					next_s.cpy = 1'b0;
					next_s.mreq = 1'b1;
					next_s.mwe = 1'b1;
					next_s.mbyte = 1'b1;
					next_s.maddr = s.dadr;
					next_s.mwdata = {8'h00, s.fill};
					next_s.st = rjm_pkg::RJM_WR;
				end
			end
			rjm_pkg::RJM_RD: begin
				// The byte read goes out as a write on the next cycle
				if (take) begin
					next_s.mreq = 1'b1;
					next_s.mwe = 1'b1;
					next_s.maddr = s.dadr;
					next_s.mwdata = {8'h00, mem_rdata_i[7:0]};
					next_s.st = rjm_pkg::RJM_WR;
				end
			end
			rjm_pkg::RJM_WR: begin
				if (take) begin
					next_s.mwe = 1'b0;
					next_s.dlen = 16'(s.dlen - 16'h0001);
					next_s.dadr = step_adr(s.dadr, s.up);
					if (s.cpy) begin
						next_s.slen = 16'(s.slen - 16'h0001);
						next_s.sadr = step_adr(s.sadr, s.up);
					end
					next_s.st = rjm_pkg::RJM_STEP;
				end
			end
			rjm_pkg::RJM_END: begin
				// Remaining source count is max(0, src - dst)
				if (!s.inl) begin
					next_s.gpr[0] = s.slen;
					next_s.gpr[1] = rjm_pkg::RST_WORD;
					next_s.gpr[2] = rjm_pkg::RST_WORD;
					next_s.gpr[3] = rjm_pkg::RST_WORD;
					next_s.gpr[4] = {8'h00, s.fill};
				end
				// In-line form touches only the program counter;
				// flags stay until the next move reaches its flag step
				next_s.done = 1'b1;
				next_s.st = rjm_pkg::RJM_IDLE;
			end
			default: begin
				next_s.st = rjm_pkg::RJM_IDLE;
			end
		endcase
	end

	// Synchronous reset clears every field, engine idle
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : rjm_top

//--- testbench/rjm_props.sv
// Port checker for the string move block
`timescale 1ns/1ns
module rjm_props #(
	parameter int ADDR_W = 8
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic mem_req_o,
	input wire logic mem_write_o,
	input wire logic mem_byte_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic [15:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Unaligned or beyond the last register
	logic hole;
	assign hole = paddr_i[1:0] != 2'h0 || paddr_i > 8'h1c;
	chk_req_held: assert property (
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable({mem_write_o,
		mem_byte_o, mem_addr_o, mem_wdata_o}))
		else $error("memory request changed before ack");
	chk_write_byte: assert property (
		mem_req_o && mem_write_o |-> mem_byte_o && mem_wdata_o[15:8] == 8'h00)
		else $error("string write not a clean byte");
	chk_word_even: assert property (
		mem_req_o && !mem_byte_o |-> !mem_write_o && !mem_addr_o[0])
		else $error("operand word access odd or written");
	chk_copy_pair: assert property (
		mem_req_o && mem_ack_i && mem_byte_o && !mem_write_o |=> mem_req_o
		&& mem_write_o && mem_wdata_o[7:0] == $past(mem_rdata_i[7:0]))
		else $error("copied byte differs from byte read");
	chk_hole_err: assert property (
		psel_i && penable_i && hole |-> pslverr_o)
		else $error("no error on unmapped access");
	chk_map_ok: assert property (
		psel_i && penable_i && !hole |-> !pslverr_o)
		else $error("error on mapped access");
	chk_ready_hi: assert property (
		psel_i && penable_i |-> pready_o && prdata_o[31:16] == 16'h0000)
		else $error("access not answered cleanly");
	chk_reset_idle: assert property (
		$fell(reset_i) |-> !mem_req_o && !pslverr_o)
		else $error("activity right after reset");
endmodule : rjm_props

bind rjm_top rjm_props #(.ADDR_W(ADDR_W)) rjm_props_inst (
	.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .mem_req_o(mem_req_o),
	.mem_write_o(mem_write_o), .mem_byte_o(mem_byte_o),
	.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
	.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));

//--- testbench/rjm_mem_model.sv
// Byte memory with word reads behind the move engine
`timescale 1ns/1ns
module rjm_mem_model (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic req_i,
	input wire logic write_i,
	input wire logic byte_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic slow_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
	// Plain always so the bench may preload and inspect it
	logic [7:0] mem [0:1023];
	logic [1:0] dly;
	logic [9:0] a;
	assign a = addr_i[9:0];
	// Data flips while idle so no stale value reads as valid
	always @(posedge clock_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (reset_i) begin
			dly <= 2'h0;
			rdata_o <= 16'h0000;
		end else if (req_i && !ack_o) begin
			if (slow_i && dly != 2'h3) begin
				dly <= dly + 2'h1;
			end else begin
				dly <= 2'h0;
				ack_o <= 1'b1;
				if (write_i) begin
					mem[a] <= wdata_i[7:0];
				end else if (byte_i) begin
					rdata_o <= {~mem[a], mem[a]};
				end else begin
					rdata_o <= {mem[a + 10'h1], mem[a]};
				end
			end
		end
	end
endmodule : rjm_mem_model

//--- testbench/tb_rjm_top.sv
// Self-checking bench for the string move block
`timescale 1ns/1ns
module tb_rjm_top;
	logic clock_i, reset_i, psel_i, penable_i, pwrite_i, slow, e;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, q, r;
	logic pready_o, pslverr_o, mem_req_o, mem_write_o, mem_byte_o;
	logic mem_ack_i;
	logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [7:0] img [0:1023];
	int failures, samples_checked, seed, j;

	rjm_top #(.ADDR_W(8)) rjm_top_inst (.clock_i(clock_i),
		.reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
		.mem_byte_o(mem_byte_o), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i));
	rjm_mem_model rjm_mem_model_inst (.clock_i(clock_i), .reset_i(reset_i),
		.req_i(mem_req_o), .write_i(mem_write_o), .byte_i(mem_byte_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .slow_i(slow),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	task tally_and_finish;
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task cmp(input string nm, input logic [31:0] x, input logic [31:0] y);
		samples_checked++;
		if (y !== x) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, x, y);
		end
	endtask : cmp

	// One APB transfer; waits for pready under a bound
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		for (n = 0; n < 9; n++) begin
			@(posedge clock_i);
			if (pready_o === 1'b1)
				break;
		end
		if (n == 9) begin
			failures++;
			tally_and_finish();
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	// Expected N Z V C from the initial lengths
	function automatic logic [31:0] flags(input logic [15:0] s, d);
		logic [16:0] t;
		t = {1'b0, s} - {1'b0, d};
		return {28'h0, t[15], t[15:0] == 16'h0,
			(s[15] != d[15]) && (d[15] == t[15]), t[16]};
	endfunction : flags

	task put_w(input logic [15:0] a, input logic [15:0] w);
		rjm_mem_model_inst.mem[a[9:0]] = w[7:0];
		rjm_mem_model_inst.mem[a[9:0] + 10'h1] = w[15:8];
	endtask : put_w

	// Run one move and compare flags, registers and all of memory
	task move(input logic inl, input logic [15:0] sl, sa, dl, da,
		input logic [7:0] f, input logic pz);
		int i, k;
		logic [15:0] t, u;
		logic [31:0] rv [0:4];
		r = $random(seed);
		slow <= r[0];
		if (inl) begin
			put_w(16'h10, 16'h20);
			put_w(16'h12, 16'h24);
			put_w(16'h14, {8'h00, f});
			put_w(16'h20, sl);
			put_w(16'h22, sa);
			put_w(16'h24, dl);
			put_w(16'h26, da);
		end
		// Image from a full snapshot, so overlap cannot hide errors
		for (i = 0; i < 1024; i++)
			img[i] = rjm_mem_model_inst.mem[i];
		for (i = 0; i < int'(dl); i++) begin
			k = int'(sl) - int'(dl) + i;
			t = da + i[15:0];
			u = sa + k[15:0];
			img[t[9:0]] = (k < 0) ? f : rjm_mem_model_inst.mem[u[9:0]];
		end
		for (i = 0; i < 5; i++)
			rv[i] = $random(seed) & 32'hffff;
		if (!inl) begin
			rv[0] = {16'h0, sl};
			rv[1] = {16'h0, sa};
			rv[2] = {16'h0, dl};
			rv[3] = {16'h0, da};
			rv[4] = {24'h0, f};
		end
		for (i = 0; i < 5; i++)
			apb(1'b1, rjm_pkg::OFF_R0 + 8'(4 * i), rv[i]);
		apb(1'b1, rjm_pkg::OFF_PC, 32'h10);
		apb(1'b1, rjm_pkg::OFF_CTRL, {30'h0, inl, 1'b1});
		if (pz) begin
			apb(1'b1, rjm_pkg::OFF_CTRL, 32'h4);
			for (k = 0; k < 50; k++) begin
				apb(1'b0, rjm_pkg::OFF_STATUS, 32'h0);
				if (q[rjm_pkg::ST_SUSP] === 1'b1)
					break;
			end
			cmp("suspended", 32'h1, {31'h0, q[rjm_pkg::ST_SUSP]});
			repeat (3) begin
				@(negedge clock_i);
				cmp("halted_req", 32'h0, {31'h0, mem_req_o});
			end
			apb(1'b1, rjm_pkg::OFF_CTRL, 32'h0);
		end
		for (k = 0; k < 400; k++) begin
			apb(1'b0, rjm_pkg::OFF_STATUS, 32'h0);
			if (q[rjm_pkg::ST_DONE] === 1'b1)
				break;
		end
		if (k == 400) begin
			failures++;
			tally_and_finish();
		end
		cmp("flags", flags(sl, dl), q & 32'h10f);
		if (!inl) begin
			rv[0] = (sl > dl) ? {16'h0, sl - dl} : 32'h0;
			rv[1] = 32'h0;
			rv[2] = 32'h0;
			rv[3] = 32'h0;
		end
		for (i = 0; i < 5; i++) begin
			apb(1'b0, rjm_pkg::OFF_R0 + 8'(4 * i), 32'h0);
			cmp("reg", rv[i], q);
		end
		apb(1'b0, rjm_pkg::OFF_PC, 32'h0);
		cmp("pc", inl ? 32'h16 : 32'h10, q);
		for (i = 0; i < 1024; i++)
			cmp("mem", {24'h0, img[i]},
				{24'h0, rjm_mem_model_inst.mem[i]});
	endtask : move

	initial begin
		seed = 32'hd7bb;
		failures = 0;
		samples_checked = 0;
		{reset_i, slow} = 2'b10;
		{psel_i, penable_i, pwrite_i} = 3'b000;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		for (j = 0; j < 1024; j++)
			rjm_mem_model_inst.mem[j] = 8'($random(seed));
		repeat (3) @(posedge clock_i);
		reset_i <= 1'b0;
		// Every register clears on reset, holes answer with error
		for (j = 0; j < 8; j++) begin
			apb(1'b0, 8'(4 * j), 32'h0);
			cmp("reset_value", 32'h0, q);
		end
		apb(1'b0, 8'h20, 32'h0);
		cmp("hole_err", 32'h1, {31'h0, e});
		cmp("hole_data", 32'h0, q);
		apb(1'b1, 8'h0a, 32'hffff);
		cmp("odd_err", 32'h1, {31'h0, e});
		apb(1'b0, rjm_pkg::OFF_R0, 32'h0);
		cmp("odd_ignored", 32'h0, q);
		// Vacant, overflow, overlapping and paused moves
		move(1'b0, 16'h0, 16'h100, 16'h5, 16'h140, 8'h2a, 1'b0);
		move(1'b1, 16'h5, 16'h100, 16'h0, 16'h140, 8'h2a, 1'b0);
		move(1'b0, 16'h8000, 16'h100, 16'h1, 16'h140, 8'h00, 1'b0);
		move(1'b1, 16'h8, 16'h104, 16'h8, 16'h100, 8'h11, 1'b1);
		move(1'b0, 16'h6, 16'h100, 16'h9, 16'h102, 8'h33, 1'b0);
		move(1'b1, 16'hc, 16'h100, 16'h6, 16'h104, 8'h44, 1'b0);
		for (j = 0; j < 16; j++) begin
			r = $random(seed);
			move(r[0], {11'h0, r[5:1]}, 16'h100 + {10'h0, r[11:6]},
				{11'h0, r[16:12]}, 16'h100 + {10'h0, r[22:17]},
				r[30:23], 1'b0);
		end
		tally_and_finish();
	end
endmodule : tb_rjm_top
